/* hdl/aoc_top.sv */
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`include "aoc_params.svh"
module aoc_top #(
   parameter int NCH = 8,
   parameter int UPDATE_CYC = `AOC_UPDATE_CYC,
   parameter int UPD_PER_S = `AOC_UPD_PER_S
) (
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // axi4-lite write
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // controller link state
   input wire logic link_up,
   // converter side
   output logic [NCH-1:0][15:0] dac_code,
   output logic dac_load,
   output logic [NCH-1:0] hold_active_flag
);
   import aoc_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_full;
      logic w_full;
      logic [11:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic run;
      aoc_mode_t mode;
      logic hold_req;
      logic dac_load;
      logic [NCH-1:0][1:0] alarm_clr;
      aoc_cfg_t [NCH-1:0] cfg;
   } aoc_top_st_t;

   localparam aoc_cfg_t CFG_RST = '{cmd: '0, offset: '0, clamp_hi: `AOC_RST_CLAMP_HI,
      clamp_lo: `AOC_RST_CLAMP_LO, prog_val: '0, fault_val: '0, ramp_rate: '0, rng: aoc_r_i020,
      ramp_en: 1'b0, hold_en: 1'b0, alarm_en: 1'b0, alarm_latch: 1'b0};
   localparam aoc_top_st_t ST_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1, mode: aoc_m_idle,
      cfg: {NCH{CFG_RST}}, default: '0};

   aoc_top_st_t st;
   aoc_top_st_t next_st;
   aoc_stat_t [NCH-1:0] stat;
   logic tick;
   logic [31:0] wm;
   logic [3:0] wsel;
   logic [3:0] rsel;

   // ************************************************************
   // helpers
   // ************************************************************
   // bit 3 says the address hits an existing channel page, bits 2:0 pick it
   function automatic logic [3:0] ch_of(input logic [11:0] a);
      logic hit;
      hit = (a[11:8] == `AOC_CH_PAGE) && (32'(a[7:5]) < NCH);
      return {hit, a[7:5]};
   endfunction : ch_of

   function automatic logic [2:0] rng_bits(input aoc_range_t r);
      case (r)
         aoc_r_v1010: return 3'h1;
         aoc_r_v05: return 3'h3;
         aoc_r_v010: return 3'h5;
         default: return 3'h0;
      endcase
   endfunction : rng_bits

   function automatic logic [31:0] reg_view(input aoc_cfg_t c, input aoc_stat_t s, input logic [4:0] off);
      logic [31:0] v;
      v = '0;
      if (off == `AOC_CH_CMD)
         v[15:0] = c.cmd;
      else if (off == `AOC_CH_CFG)
         v[6:0] = {c.alarm_latch, c.alarm_en, c.hold_en, c.ramp_en, rng_bits(c.rng)};
      else if (off == `AOC_CH_OFFS)
         v[15:0] = c.offset;
      else if (off == `AOC_CH_RATE)
         v[15:0] = c.ramp_rate;
      else if (off == `AOC_CH_CLAMP)
         v = {c.clamp_hi, c.clamp_lo};
      else if (off == `AOC_CH_SAFE)
         v = {c.fault_val, c.prog_val};
      else if (off == `AOC_CH_STAT)
      begin
         v[15:0] = s.echo;
         v[`AOC_ST_HOLD] = s.hold;
         v[`AOC_ST_CLAMPED] = s.clamped;
         v[`AOC_ST_HI] = s.hi_alarm;
         v[`AOC_ST_LO] = s.lo_alarm;
      end
      return v;
   endfunction : reg_view

   function automatic logic [31:0] merge(input logic [31:0] old, dat, input logic [3:0] strb);
      logic [31:0] v;
      v = old;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            v[8*i +: 8] = dat[8*i +: 8];
      return v;
   endfunction : merge

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      next_st = st;
      next_st.hold_req = 1'b0;
      next_st.alarm_clr = '0;
      next_st.dac_load = tick;
      wsel = ch_of(st.aw_addr);
      rsel = ch_of(s_axi_araddr);
      wm = '0;

      // connection and run/program sequencing shared by all channels
      case (st.mode)
         aoc_m_idle:
            if (link_up)
            begin
               next_st.mode = st.run ? aoc_m_run : aoc_m_prog;
               next_st.hold_req = st.run;
            end
         aoc_m_run:
            if (!link_up)
               next_st.mode = aoc_m_fault;
            else if (!st.run)
               next_st.mode = aoc_m_prog;
         aoc_m_prog:
            if (!link_up)
               next_st.mode = aoc_m_fault;
            else if (st.run)
            begin
               next_st.mode = aoc_m_run;
               next_st.hold_req = 1'b1;
            end
         aoc_m_fault:
            if (link_up)
            begin
               next_st.mode = st.run ? aoc_m_run : aoc_m_prog;
               next_st.hold_req = st.run;
            end
         default: next_st.mode = aoc_m_idle;
      endcase

      // write address and data are taken independently, in either order
      if (s_axi_awvalid && st.awready)
      begin
         next_st.aw_full = 1'b1;
         next_st.awready = 1'b0;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st.wready)
      begin
         next_st.w_full = 1'b1;
         next_st.wready = 1'b0;
         next_st.w_data = s_axi_wdata;
         next_st.w_strb = s_axi_wstrb;
      end
      if (st.aw_full && st.w_full && !st.bvalid)
      begin
         next_st.bvalid = 1'b1;
         next_st.bresp = `AOC_RESP_OK;
         if (st.aw_addr[11:2] == `AOC_REG_CTRL >> 2)
         begin
            wm = merge({31'h0, st.run}, st.w_data, st.w_strb);
            next_st.run = wm[`AOC_CTRL_RUN];
         end
         else if (st.aw_addr[11:2] == `AOC_REG_GSTAT >> 2)
         begin
            wm = '0;
         end
         else if (wsel[3])
         begin
            wm = merge(reg_view(st.cfg[wsel[2:0]], stat[wsel[2:0]], st.aw_addr[4:0]), st.w_data, st.w_strb);
            if (st.aw_addr[4:2] == `AOC_CH_CMD >> 2)
               next_st.cfg[wsel[2:0]].cmd = wm[15:0];
            else if (st.aw_addr[4:2] == `AOC_CH_CFG >> 2)
            begin
               next_st.cfg[wsel[2:0]].ramp_en = wm[`AOC_CFG_RAMP];
               next_st.cfg[wsel[2:0]].hold_en = wm[`AOC_CFG_HOLD];
               next_st.cfg[wsel[2:0]].alarm_en = wm[`AOC_CFG_ALEN];
               next_st.cfg[wsel[2:0]].alarm_latch = wm[`AOC_CFG_ALLAT];
               // a type and range pair that the output stage cannot make is ignored
               if (wm[2:0] == 3'h0)
                  next_st.cfg[wsel[2:0]].rng = aoc_r_i020;
               else if (wm[2:0] == 3'h1)
                  next_st.cfg[wsel[2:0]].rng = aoc_r_v1010;
               else if (wm[2:0] == 3'h3)
                  next_st.cfg[wsel[2:0]].rng = aoc_r_v05;
               else if (wm[2:0] == 3'h5)
                  next_st.cfg[wsel[2:0]].rng = aoc_r_v010;
            end
            else if (st.aw_addr[4:2] == `AOC_CH_OFFS >> 2)
               next_st.cfg[wsel[2:0]].offset = wm[15:0];
            else if (st.aw_addr[4:2] == `AOC_CH_RATE >> 2)
               next_st.cfg[wsel[2:0]].ramp_rate = wm[15:0];
            else if (st.aw_addr[4:2] == `AOC_CH_CLAMP >> 2)
            begin
               // limits move only on this write; nothing rescales them
               next_st.cfg[wsel[2:0]].clamp_hi = wm[31:16];
               next_st.cfg[wsel[2:0]].clamp_lo = wm[15:0];
            end
            else if (st.aw_addr[4:2] == `AOC_CH_SAFE >> 2)
            begin
               next_st.cfg[wsel[2:0]].fault_val = wm[31:16];
               next_st.cfg[wsel[2:0]].prog_val = wm[15:0];
            end
            else if (st.aw_addr[4:2] == `AOC_CH_STAT >> 2)
            begin
               // write one to clear, only the strobed lane counts
               next_st.alarm_clr[wsel[2:0]] = {st.w_strb[2] & st.w_data[`AOC_ST_HI],
                                               st.w_strb[2] & st.w_data[`AOC_ST_LO]};
            end
         end
         else
         begin
            next_st.bresp = `AOC_RESP_SLVERR;
         end
      end
      if (st.bvalid && s_axi_bready)
      begin
         next_st.bvalid = 1'b0;
         next_st.aw_full = 1'b0;
         next_st.w_full = 1'b0;
         next_st.awready = 1'b1;
         next_st.wready = 1'b1;
      end

      // read answers one cycle after the address is taken
      if (s_axi_arvalid && st.arready)
      begin
         next_st.arready = 1'b0;
         next_st.rvalid = 1'b1;
         next_st.rresp = `AOC_RESP_OK;
         next_st.rdata = '0;
         if (s_axi_araddr[11:2] == `AOC_REG_CTRL >> 2)
            next_st.rdata[`AOC_CTRL_RUN] = st.run;
         else if (s_axi_araddr[11:2] == `AOC_REG_GSTAT >> 2)
         begin
            next_st.rdata[1:0] = st.mode;
            next_st.rdata[`AOC_GST_LINK] = link_up;
         end
         else if (rsel[3])
            next_st.rdata = reg_view(st.cfg[rsel[2:0]], stat[rsel[2:0]], s_axi_araddr[4:0]);
         else
            next_st.rresp = `AOC_RESP_SLVERR;
      end
      if (st.rvalid && s_axi_rready)
      begin
         next_st.rvalid = 1'b0;
         next_st.arready = 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         st <= ST_RST;
      else if (ce)
         st <= next_st;
   end

   // ************************************************************
   // update timer and channels
   // ************************************************************
   aoc_tick #(
      .PERIOD_CYC(UPDATE_CYC)
   ) u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .tick(tick)
   );

   for (genvar i = 0; i < NCH; i++)
   begin : g_ch
      aoc_chan #(
         .UPD_PER_S(UPD_PER_S)
      ) u_chan (
         .aclk(aclk),
         .aresetn(aresetn),
         .ce(ce),
         .tick(tick),
         .hold_req(st.hold_req),
         .alarm_clr(st.alarm_clr[i]),
         .mode(st.mode),
         .cfg(st.cfg[i]),
         .stat(stat[i])
      );
      assign dac_code[i] = stat[i].echo;
      assign hold_active_flag[i] = stat[i].hold;
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign s_axi_awready = st.awready;
   assign s_axi_wready = st.wready;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = st.arready;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;
   assign dac_load = st.dac_load;
endmodule : aoc_top

/* pkg/aoc_params.svh */
`ifndef AOC_PARAMS_SVH
`define AOC_PARAMS_SVH
// ************************************************************
// timing
// ************************************************************
`define AOC_CLK_MHZ 25
`define AOC_UPDATE_US 1000
`define AOC_UPDATE_CYC (`AOC_UPDATE_US * `AOC_CLK_MHZ)
`define AOC_UPD_PER_S (1000000 / `AOC_UPDATE_US)
// 0.1% of the 65536-code full scale
`define AOC_HOLD_TOL 17'h00041
// ************************************************************
// register map
// ************************************************************
`define AOC_REG_CTRL 12'h000
`define AOC_REG_GSTAT 12'h004
`define AOC_CH_PAGE 4'h1
`define AOC_CH_CMD 5'h00
`define AOC_CH_CFG 5'h04
`define AOC_CH_OFFS 5'h08
`define AOC_CH_RATE 5'h0C
`define AOC_CH_CLAMP 5'h10
`define AOC_CH_SAFE 5'h14
`define AOC_CH_STAT 5'h18
// ************************************************************
// field positions
// ************************************************************
`define AOC_CTRL_RUN 0
`define AOC_GST_LINK 2
`define AOC_CFG_RAMP 3
`define AOC_CFG_HOLD 4
`define AOC_CFG_ALEN 5
`define AOC_CFG_ALLAT 6
`define AOC_ST_HOLD 16
`define AOC_ST_CLAMPED 17
`define AOC_ST_HI 18
`define AOC_ST_LO 19
// ************************************************************
// reset values and limits
// ************************************************************
`define AOC_RST_CLAMP_HI 16'h7FFF
`define AOC_RST_CLAMP_LO 16'h8000
`define AOC_BIP_LO 16'h8000
`define AOC_UNI_LO 16'h0000
`define AOC_FS_HI 16'h7FFF
`define AOC_RESP_OK 2'h0
`define AOC_RESP_SLVERR 2'h2
`endif

/* pkg/aoc_pkg.sv */
package aoc_pkg;
   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {aoc_r_i020, aoc_r_v1010, aoc_r_v05, aoc_r_v010} aoc_range_t;
   typedef enum logic [1:0] {aoc_m_idle, aoc_m_run, aoc_m_prog, aoc_m_fault} aoc_mode_t;
   typedef struct packed {
      logic signed [15:0] cmd;
      logic signed [15:0] offset;
      logic signed [15:0] clamp_hi;
      logic signed [15:0] clamp_lo;
      logic signed [15:0] prog_val;
      logic signed [15:0] fault_val;
      logic [15:0] ramp_rate;
      aoc_range_t rng;
      logic ramp_en;
      logic hold_en;
      logic alarm_en;
      logic alarm_latch;
   } aoc_cfg_t;
   typedef struct packed {
      logic signed [15:0] echo;
      logic hold;
      logic clamped;
      logic hi_alarm;
      logic lo_alarm;
   } aoc_stat_t;
endpackage : aoc_pkg

/* hdl/aoc_tick.sv */
`timescale 1ns/100ps
`include "aoc_params.svh"
module aoc_tick #(
   parameter int PERIOD_CYC = `AOC_UPDATE_CYC
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // update strobe
   output logic tick
);
   import aoc_pkg::*;
   localparam int CW = $clog2(PERIOD_CYC + 1);
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic tick;
   } aoc_tick_st_t;
   aoc_tick_st_t st;
   aoc_tick_st_t next_st;

   always_comb
   begin
      next_st = st;
      next_st.tick = 1'b0;
      if (st.cnt == CW'(PERIOD_CYC - 1))
      begin
         next_st.cnt = '0;
         next_st.tick = 1'b1;
      end
      else
      begin
         next_st.cnt = st.cnt + CW'(1);
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         st <= '0;
      else if (ce)
         st <= next_st;
   end

   assign tick = st.tick;
endmodule : aoc_tick

/* hdl/aoc_chan.sv */
`timescale 1ns/100ps
`include "aoc_params.svh"
module aoc_chan #(
   parameter int UPD_PER_S = `AOC_UPD_PER_S
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // control
   input wire logic tick,
   input wire logic hold_req,
   input wire logic [1:0] alarm_clr,
   input wire aoc_pkg::aoc_mode_t mode,
   input wire aoc_pkg::aoc_cfg_t cfg,
   // status
   output aoc_pkg::aoc_stat_t stat
);
   import aoc_pkg::*;
   aoc_stat_t st;
   aoc_stat_t next_st;
   logic signed [15:0] req;
   logic signed [15:0] target;
   logic signed [15:0] ramped;
   logic signed [15:0] rng_lo;
   logic signed [16:0] diff;
   logic signed [16:0] rdiff;
   logic [16:0] adiff;
   logic [16:0] ardiff;
   logic [15:0] step;
   logic ex_hi;
   logic ex_lo;

   function automatic logic signed [15:0] sat(input logic signed [16:0] v);
      if (v > 17'sh07FFF)
         return `AOC_FS_HI;
      else if (v < -17'sh08000)
         return `AOC_BIP_LO;
      return v[15:0];
   endfunction : sat

   function automatic logic signed [15:0] lim(input logic signed [15:0] v, lo, hi);
      if (v > hi)
         return hi;
      else if (v < lo)
         return lo;
      return v;
   endfunction : lim

   always_comb
   begin
      next_st = st;
      req = sat(17'(cfg.cmd) + 17'(cfg.offset));
      case (mode)
         aoc_m_run: target = req;
         aoc_m_prog: target = cfg.prog_val;
         aoc_m_fault: target = cfg.fault_val;
         default: target = st.echo;
      endcase
      // step per update = rate in units per second over updates per second
      step = 16'(cfg.ramp_rate / 16'(UPD_PER_S));
      if (step == 16'h0000)
         step = 16'h0001;
      diff = 17'(target) - 17'(st.echo);
      adiff = diff[16] ? 17'(-diff) : 17'(diff);
      if (!cfg.ramp_en || adiff <= {1'b0, step})
         ramped = target;
      else if (diff[16])
         ramped = 16'(st.echo - $signed({1'b0, step}));
      else
         ramped = 16'(st.echo + $signed({1'b0, step}));
      rng_lo = (cfg.rng == aoc_r_v1010) ? `AOC_BIP_LO : `AOC_UNI_LO;
      rdiff = 17'(req) - 17'(st.echo);
      ardiff = rdiff[16] ? 17'(-rdiff) : 17'(rdiff);
      ex_hi = (mode == aoc_m_run) && !st.hold && (req > cfg.clamp_hi);
      ex_lo = (mode == aoc_m_run) && !st.hold && (req < cfg.clamp_lo);
      // a latched alarm clears on request, but a set in the same cycle wins
      if (cfg.alarm_latch && alarm_clr[1])
         next_st.hi_alarm = 1'b0;
      if (cfg.alarm_latch && alarm_clr[0])
         next_st.lo_alarm = 1'b0;
      if (mode != aoc_m_run)
         next_st.hold = 1'b0;
      if (tick)
      begin
         next_st.clamped = ex_hi || ex_lo;
         next_st.hi_alarm = cfg.alarm_en && (ex_hi || (cfg.alarm_latch && next_st.hi_alarm));
         next_st.lo_alarm = cfg.alarm_en && (ex_lo || (cfg.alarm_latch && next_st.lo_alarm));
         if (mode == aoc_m_run && st.hold)
         begin
            // output frozen; release once the request has caught up
            if (ardiff <= `AOC_HOLD_TOL)
               next_st.hold = 1'b0;
         end
         else if (mode != aoc_m_idle)
         begin
            // clamp after the ramp, then limit to the range; where the two disagree the range limit wins
            next_st.echo = lim(lim(ramped, cfg.clamp_lo, cfg.clamp_hi), rng_lo, `AOC_FS_HI);
         end
      end
      if (!cfg.alarm_en)
      begin
         next_st.hi_alarm = 1'b0;
         next_st.lo_alarm = 1'b0;
      end
      if (hold_req && cfg.hold_en)
         next_st.hold = 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         st <= '0;
      else if (ce)
         st <= next_st;
   end

   assign stat = st;
endmodule : aoc_chan

/* sim/aoc_top_chk.sv */
`timescale 1ns/100ps
module aoc_chk #(
   parameter int NCH = 8,
   parameter int UPDATE_CYC = 20
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // bus
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // link and converter
   input wire logic link_up,
   input wire logic [NCH-1:0][15:0] dac_code,
   input wire logic dac_load,
   input wire logic [NCH-1:0] hold_active_flag
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // enabled cycles since the last load, since a low enable freezes the update timer;
   // seen keeps the first load after reset unchecked
   logic [15:0] gap;
   logic seen;
   always_ff @(posedge aclk)
   begin
      gap <= (!aresetn || (ce && dac_load)) ? 16'h0000 : gap + 16'(ce);
      seen <= aresetn && (seen || dac_load);
   end
   property p_bresp_stands; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_bresp_stands: assert property (p_bresp_stands) else $error("write response dropped");
   property p_rdata_stands; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rdata_stands: assert property (p_rdata_stands) else $error("read data dropped");
   property p_read_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
   a_read_answer: assert property (p_read_answer) else $error("read not answered");
   property p_write_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_write_busy: assert property (p_write_busy) else $error("write taken while busy");
   property p_load_pulse; dac_load |=> !dac_load; endproperty
   a_load_pulse: assert property (p_load_pulse) else $error("load longer than one cycle");
   property p_code_with_load; $changed(dac_code) |-> dac_load; endproperty
   a_code_with_load: assert property (p_code_with_load) else $error("code changed off update");
   property p_load_period; dac_load && seen |-> gap == UPDATE_CYC - 1; endproperty
   a_load_period: assert property (p_load_period) else $error("update period wrong");
   property p_hold_off_link; !link_up [*3] |-> hold_active_flag == '0; endproperty
   a_hold_off_link: assert property (p_hold_off_link) else $error("hold without link");
   c_hold: cover property (hold_active_flag != '0);
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_load: cover property (dac_load && seen);
endmodule : aoc_chk
bind aoc_top aoc_chk #(.NCH(NCH), .UPDATE_CYC(UPDATE_CYC)) i_chk (.*);

/* sim/aoc_host.sv */
`timescale 1ns/100ps
module aoc_host (
   // clock
   input wire logic aclk,
   // connection
   output logic link_up
);
   initial link_up = 1'b0;
   // connection made or lost, changed just after an edge
   task automatic connect(input logic up);
      @(posedge aclk);
      link_up <= up;
   endtask : connect
endmodule : aoc_host

/* sim/aoc_top_tb.sv */
`timescale 1ns/100ps
module aoc_top_tb;
   // ************************************************************
   // bench
   // ************************************************************
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic link_up, dac_load, ce;
   logic [3:0] wstrb;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic [7:0][15:0] dac_code;
   logic [7:0] hold;
   logic [33:0] got;
   int miscompares = 0;
   int n_tests = 0;
   aoc_top #(.UPDATE_CYC(20)) i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .link_up(link_up), .dac_code(dac_code), .dac_load(dac_load), .hold_active_flag(hold));
   aoc_host i_host (.aclk(aclk), .link_up(link_up));
   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] seen);
      n_tests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // got carries the write response once the write is answered
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
      @(posedge aclk);
      {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, s, 3'b111};
      do
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      got = {32'h0, bresp};
      bready <= 1'b0;
   endtask : wr
   // got carries the response code above the read word
   task automatic rchk(input string what, input logic [11:0] a, input logic [33:0] exp);
      @(posedge aclk);
      {araddr, arvalid, rready} <= {a, 2'b11};
      do
      begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      got = {rresp, rdata};
      rready <= 1'b0;
      chk(what, exp, got);
   endtask : rchk
   task automatic loads(input int n);
      repeat (n)
      begin
         do @(posedge aclk); while (dac_load !== 1'b1);
      end
   endtask : loads
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
      begin
         $display("bench passed");
      end
      else
      begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop
   initial
   begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      report_and_stop();
   end
   // ************************************************************
   // scenarios: ch0 +-10V clamped latching alarms, ch1 ramping, ch2 hold
   // ************************************************************
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
      ce = 1'b1;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rchk("clamp", 12'h110, 34'h0_7FFF8000);
      rchk("cfg", 12'h104, 34'h0);
      rchk("ninth", 12'h200, 34'h2_00000000);
      wr(12'h200, 32'h00000001);
      chk("bresp", 34'h2, got);
      wr(12'h104, 32'h00000061);
      chk("bresp", 34'h0, got);
      wr(12'h108, 32'h00000064);
      wr(12'h110, 32'h03E8FE0C);
      wr(12'h114, 32'hFED400C8);
      wr(12'h124, 32'h0000000B);
      rchk("cfg1", 12'h124, 34'hB);
      // an unsupported type and range pair leaves the range alone
      wr(12'h164, 32'h0000000A);
      rchk("cfg3", 12'h164, 34'h8);
      wr(12'h12C, 32'h00001388);
      wr(12'h144, 32'h00000015);
      rchk("cfg2", 12'h144, 34'h15);
      wr(12'h140, 32'h000001F4);
      wr(12'h000, 32'h00000001);
      i_host.connect(1'b1);
      loads(2);
      chk("hold", 34'h4, {31'h0, hold[2:0]});
      wr(12'h100, 32'h000007D0);
      loads(2);
      rchk("ch0", 12'h118, 34'h0_000603E8);
      chk("dac0", 34'h3E8, {18'h0, dac_code[0]});
      wr(12'h100, 32'h0000FC18);
      loads(2);
      rchk("ch0", 12'h118, 34'h0_000EFE0C);
      wr(12'h100, 32'h0000012C);
      loads(2);
      rchk("ch0", 12'h118, 34'h0_000C0190);
      // lane 2 not strobed, so the latched alarms must survive
      wr(12'h118, 32'h000C0000, 4'h3);
      rchk("ch0", 12'h118, 34'h0_000C0190);
      wr(12'h118, 32'h000C0000);
      rchk("ch0", 12'h118, 34'h190);
      wr(12'h120, 32'h00000032);
      loads(3);
      // a low enable longer than one update period must keep the ramp where it stands
      ce <= 1'b0;
      repeat (30) @(posedge aclk);
      ce <= 1'b1;
      rchk("ch1", 12'h138, 34'hF);
      rchk("ch2", 12'h158, 34'h10000);
      wr(12'h140, 32'h0000003C);
      loads(1);
      rchk("ch2", 12'h158, 34'h0);
      loads(1);
      rchk("ch2", 12'h158, 34'h3C);
      wr(12'h000, 32'h00000000);
      loads(2);
      rchk("ch0", 12'h118, 34'hC8);
      rchk("mode", 12'h004, 34'h6);
      i_host.connect(1'b0);
      loads(2);
      rchk("ch0", 12'h118, 34'hFED4);
      rchk("mode", 12'h004, 34'h3);
      report_and_stop();
   end
endmodule : aoc_top_tb
